// ==== acc_pkg.sv ====
package acc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_CTRL_ADDR  = 8'h61;
    localparam logic [7:0] MODE_CFG_ADDR  = 8'h62;
    localparam logic [7:0] BYPASS_ADDR    = 8'h64;
    localparam logic [7:0] AVG_ADDR       = 8'h68;
    localparam logic [7:0] FLAGS_ADDR     = 8'h6a;
    localparam logic [7:0] PIN_CFG_ADDR   = 8'h6b;
    localparam logic [7:0] SW_TRIG_ADDR   = 8'h6c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RUN_CTRL_RST   = 8'h01;
    localparam logic [7:0] MODE_CFG_RST   = 8'h01;
    localparam logic [7:0] BYPASS_RST     = 8'h02;
    localparam logic [7:0] AVG_RST        = 8'h61;
    localparam logic [7:0] PIN_CFG_RST    = 8'h00;
    localparam logic [7:0] SW_TRIG_RST    = 8'h01;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RUN_EN_BIT   = 0;
    localparam int FG_SEL_BIT   = 0;
    localparam int BG_EN_BIT    = 1;
    localparam int FG_OS_BIT    = 2;
    localparam int BG_OS_BIT    = 3;
    localparam int IDLE_LSB     = 0;
    localparam int LIN_AVG_LSB  = 0;
    localparam int OFFSET_AVERAGING_LSB   = 4;
    localparam int DONE_BIT     = 0;
    localparam int HALT_BIT     = 1;
    localparam int TRIG_SRC_BIT = 0;
    localparam int STAT_SEL_LSB = 1;
    localparam int SW_TRIG_BIT  = 0;

    // Status pin source codes
    localparam logic [1:0] STAT_SRC_DONE  = 2'h0;
    localparam logic [1:0] STAT_SRC_HALT  = 2'h1;
    localparam logic [1:0] STAT_SRC_FAULT = 2'h2;

    // Engine timing: cycles spent in one foreground pass
    localparam logic [7:0] FG_CYCLES = 8'h10;

endpackage

// ==== acc_cal_regs.sv ====
// Contract
// - Run enable bit0, reset 1, low holds calibration
// - Run enable low resets processing clock dividers
// - Foreground select resets values, runs or skips
// - Background enable runs continuous background calibration
// - Foreground offset calibration only with foreground
// - Background offset calibration only with background
// - Idle core select names disabled core
// - Offset averaging bits 6:4, reset 6
// - Linearity averaging bits 2:0, reset 1
// - Halted flag: background stopped or foreground done
// - Foreground complete flag after finish or skip
// - Status pin source select, 3 gives low
// - Trigger source: software bit or pin
// - Software trigger bit resets 1, replaces pin
`timescale 1ns/1ps

module acc_cal_regs (
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       calibration_trigger_pin_i,
    input  wire logic       fault_i,
    output logic            calibration_status_pin_o,
    output logic            cal_reset_o,
    output logic            div_reset_o,
    output logic            fg_run_o,
    output logic            fg_offset_o,
    output logic            bg_run_o,
    output logic            bg_offset_o,
    output logic      [1:0] idle_core_o,
    output logic      [1:0] standin_core_o,
    output logic      [2:0] offset_averaging_o,
    output logic      [2:0] linearity_averaging_o,
    output logic            cal_trigger_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ENG_HOLD = 4'h1,
        ENG_FG   = 4'h2,
        ENG_BG   = 4'h4,
        ENG_IDLE = 4'h8
    } acc_eng_t;

    typedef struct packed {
        logic [7:0] run_ctrl;
        logic [7:0] mode_cfg;
        logic [7:0] bypass;
        logic [7:0] avg;
        logic [7:0] pin_cfg;
        logic [7:0] sw_trig;
        logic       done;
        logic       halt;
        acc_eng_t   eng;
        logic [7:0] cnt;
        logic [7:0] rdata;
        logic       stat_pin;
    } acc_state_t;

    acc_state_t s_q;
    acc_state_t s_d;
    logic       rst_meta_q;
    logic       rst_sync_q;
    logic       trig;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Trigger source mux
        trig = s_q.pin_cfg[acc_pkg::TRIG_SRC_BIT] ? calibration_trigger_pin_i
                                                  : s_q.sw_trig[acc_pkg::SW_TRIG_BIT];
        // Whole bytes written so reserved bits read back
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                acc_pkg::RUN_CTRL_ADDR: s_d.run_ctrl = reg_wdata_i;
                acc_pkg::MODE_CFG_ADDR: s_d.mode_cfg = reg_wdata_i;
                acc_pkg::BYPASS_ADDR:   s_d.bypass   = reg_wdata_i;
                acc_pkg::AVG_ADDR:      s_d.avg      = reg_wdata_i;
                acc_pkg::PIN_CFG_ADDR:  s_d.pin_cfg  = reg_wdata_i;
                acc_pkg::SW_TRIG_ADDR:  s_d.sw_trig  = reg_wdata_i;
                default: ;
            endcase
        end
        // Engine sequencing
        if (!s_q.run_ctrl[acc_pkg::RUN_EN_BIT]) begin
            // Held engine restarts from scratch on next enable
            s_d.eng  = ENG_HOLD;
            s_d.done = 1'b0;
            s_d.halt = 1'b0;
            s_d.cnt  = 8'h00;
        end else begin
            unique case (s_q.eng)
                ENG_HOLD: begin
                    s_d.cnt = 8'h00;
                    if (trig) begin
                        s_d.eng = s_q.mode_cfg[acc_pkg::FG_SEL_BIT] ? ENG_FG : ENG_IDLE;
                    end
                end
                ENG_FG: begin
                    s_d.cnt = s_q.cnt + 8'h01;
                    if (s_q.cnt == acc_pkg::FG_CYCLES - 8'h01) begin
                        s_d.eng = ENG_IDLE;
                    end
                end
                ENG_IDLE: begin
                    s_d.done = 1'b1;
                    s_d.halt = 1'b1;
                    if (s_q.mode_cfg[acc_pkg::BG_EN_BIT] && trig) begin
                        s_d.eng = ENG_BG;
                    end
                end
                ENG_BG: begin
                    // Background runs while trigger and background enable are high, stops when either goes low
                    s_d.halt = 1'b0;
                    if (!trig || !s_q.mode_cfg[acc_pkg::BG_EN_BIT]) begin
                        s_d.eng = ENG_IDLE;
                    end
                end
                default: s_d.eng = ENG_HOLD;
            endcase
        end
        // Read data, status assembled from engine flags
        s_d.rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                acc_pkg::RUN_CTRL_ADDR: s_d.rdata = s_q.run_ctrl;
                acc_pkg::MODE_CFG_ADDR: s_d.rdata = s_q.mode_cfg;
                acc_pkg::BYPASS_ADDR:   s_d.rdata = s_q.bypass;
                acc_pkg::AVG_ADDR:      s_d.rdata = s_q.avg;
                acc_pkg::FLAGS_ADDR:    s_d.rdata = {6'h00, s_q.halt, s_q.done};
                acc_pkg::PIN_CFG_ADDR:  s_d.rdata = s_q.pin_cfg;
                acc_pkg::SW_TRIG_ADDR:  s_d.rdata = s_q.sw_trig;
                default:                s_d.rdata = 8'h00;
            endcase
        end
        // Status pin source
        unique case (s_q.pin_cfg[acc_pkg::STAT_SEL_LSB +: 2])
            acc_pkg::STAT_SRC_DONE:  s_d.stat_pin = s_q.done;
            acc_pkg::STAT_SRC_HALT:  s_d.stat_pin = s_q.halt;
            acc_pkg::STAT_SRC_FAULT: s_d.stat_pin = fault_i;
            default:                 s_d.stat_pin = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_q          <= '0;
            s_q.run_ctrl <= acc_pkg::RUN_CTRL_RST;
            s_q.mode_cfg <= acc_pkg::MODE_CFG_RST;
            s_q.bypass   <= acc_pkg::BYPASS_RST;
            s_q.avg      <= acc_pkg::AVG_RST;
            s_q.pin_cfg  <= acc_pkg::PIN_CFG_RST;
            s_q.sw_trig  <= acc_pkg::SW_TRIG_RST;
            s_q.eng      <= ENG_HOLD;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_o              = s_q.rdata;
    assign calibration_status_pin_o = s_q.stat_pin;
    assign cal_reset_o              = !s_q.run_ctrl[acc_pkg::RUN_EN_BIT];
    assign div_reset_o              = !s_q.run_ctrl[acc_pkg::RUN_EN_BIT];
    assign fg_run_o                 = (s_q.eng == ENG_FG);
    assign fg_offset_o              = fg_run_o && s_q.mode_cfg[acc_pkg::FG_OS_BIT];
    assign bg_run_o                 = (s_q.eng == ENG_BG);
    assign bg_offset_o              = bg_run_o && s_q.mode_cfg[acc_pkg::BG_OS_BIT];
    // Core named here comes straight from bypass bits 1:0, whatever the background enable
    assign idle_core_o              = s_q.bypass[acc_pkg::IDLE_LSB +: 2];
    assign standin_core_o           = 2'h1;
    assign offset_averaging_o       = s_q.avg[acc_pkg::OFFSET_AVERAGING_LSB +: 3];
    assign linearity_averaging_o    = s_q.avg[acc_pkg::LIN_AVG_LSB +: 3];
    assign cal_trigger_o            = trig;

endmodule

// ==== acc_cal_regs_checker.sv ====
`timescale 1ns/1ps
module acc_cal_regs_checker (
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic       cal_reset_o,
    input wire logic       div_reset_o,
    input wire logic       fg_run_o,
    input wire logic       fg_offset_o,
    input wire logic       bg_run_o,
    input wire logic       bg_offset_o,
    input wire logic [1:0] standin_core_o,
    input wire logic       cal_trigger_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_div; div_reset_o == cal_reset_o; endproperty
    a_div: assert property (p_div) else $error("divider reset differs");
    property p_hold; cal_reset_o |=> !fg_run_o && !bg_run_o; endproperty
    a_hold: assert property (p_hold) else $error("engine runs in hold");
    property p_fg_trig; $rose(fg_run_o) |-> $past(cal_trigger_o); endproperty
    a_fg_trig: assert property (p_fg_trig) else $error("pass without trigger");
    property p_bg_trig; $rose(bg_run_o) |-> $past(cal_trigger_o) && !fg_run_o; endproperty
    a_bg_trig: assert property (p_bg_trig) else $error("background without trigger");
    property p_fg_os; fg_offset_o |-> fg_run_o; endproperty
    a_fg_os: assert property (p_fg_os) else $error("offset outside pass");
    property p_bg_os; bg_offset_o |-> bg_run_o; endproperty
    a_bg_os: assert property (p_bg_os) else $error("offset outside background");
    property p_standin; standin_core_o == 2'h1; endproperty
    a_standin: assert property (p_standin) else $error("wrong stand-in core");
    // Slack of a few cycles covers only the exit of the pass; entry is fixed at the rise
    property p_fg_len;
        disable iff (!rstn_i || cal_reset_o) $rose(fg_run_o) |-> fg_run_o[*8] ##1 fg_run_o[*6] ##[1:4] !fg_run_o;
    endproperty
    a_fg_len: assert property (p_fg_len) else $error("pass length wrong");
endmodule
bind acc_cal_regs acc_cal_regs_checker acc_cal_regs_checker_inst (.*);

// ==== acc_host_model.sv ====
`timescale 1ns/1ps
module acc_host_model (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    logic link_en = 1'b0;
    initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = 18'h0;
    // Released address and data lines are inverted and strobes cleared, so stale values never look valid
    task automatic acc(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
        if (wr && a == 8'h61 && !d[0]) link_en = 1'b0;
        if (wr && a == 8'h64) link_en = 1'b0;
        @(posedge core_clk_i) #1;
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {wr, !wr, a, d};
        @(posedge core_clk_i) #1;
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'h0, ~a, ~d};
        q = reg_rdata_i;
        if (wr && a == 8'h61 && d[0]) link_en = 1'b1;
    endtask
endmodule

// ==== acc_cal_regs_tb.sv ====
`timescale 1ns/1ps
module acc_cal_regs_tb;
    logic       core_clk_i = 1'b0, rstn_i = 1'b0, calibration_trigger_pin_i = 1'b0, fault_i = 1'b0;
    logic       reg_wr_i, reg_rd_i, cal_reset_o, div_reset_o, fg_run_o, fg_offset_o, bg_run_o, bg_offset_o;
    logic       cal_trigger_o, calibration_status_pin_o;
    logic [1:0] idle_core_o, standin_core_o;
    logic [2:0] offset_averaging_o, linearity_averaging_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    int         mdl [int];
    int         failures = 0, comparisons = 0;
    acc_cal_regs acc_cal_regs_inst (.*);
    acc_host_model acc_host_model_inst (.core_clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    initial forever #2 core_clk_i = ~core_clk_i;
    task automatic chk(input string n, input logic [7:0] s, input int e);
        comparisons++;
        if (s !== e[7:0]) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e[7:0], s);
        end
    endtask
    task automatic op(input logic w, input int a, d);
        logic [7:0] q;
        acc_host_model_inst.acc(w, a[7:0], d[7:0], q);
        if (w && mdl.exists(a) && a != 8'h6a) mdl[a] = d & 8'hff;
        if (!w) chk($sformatf("reg %h", a[7:0]), q, mdl.exists(a) ? mdl[a] : 0);
    endtask
    // Flags move on their own, so they are polled under a bound
    task automatic poll(input int e);
        logic [7:0] q;
        for (int i = 0; i < 60 && q !== e[7:0]; i++) acc_host_model_inst.acc(1'b0, 8'h6a, 8'h00, q);
        mdl[8'h6a] = e;
        chk("flags", q, e);
        if (q !== e[7:0]) final_report;
    endtask
    task automatic outs;
        int p;
        p = mdl[8'h6b] >> 1;
        chk("avg", {1'b0, offset_averaging_o, 1'b0, linearity_averaging_o}, mdl[8'h68] & 8'h77);
        chk("idle", {6'h0, idle_core_o}, mdl[8'h64] & 8'h3);
        chk("standin", {6'h0, standin_core_o}, 1);
        chk("hold", {6'h0, div_reset_o, cal_reset_o}, mdl[8'h61] & 1 ? 0 : 3);
        chk("trig", {7'h0, cal_trigger_o}, p & 0 | mdl[8'h6b] & 1 ? calibration_trigger_pin_i : mdl[8'h6c] & 1);
        chk("stat", {7'h0, calibration_status_pin_o}, p[1] ? !p[0] && fault_i : mdl[8'h6a] >> p[0] & 1);
    endtask
    task final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        void'($urandom(31331));
        mdl = '{8'h61: 1, 8'h62: 1, 8'h64: 2, 8'h68: 8'h61, 8'h6a: 0, 8'h6b: 0, 8'h6c: 1};
        repeat (5) @(posedge core_clk_i);
        #1 rstn_i = 1'b1;
        repeat (3) @(posedge core_clk_i);
        poll(3);
        foreach (mdl[a]) op(1'b0, a, 0);
        outs;
        $display("reset values done");
        fault_i = 1'($urandom);
        op(1'b1, 8'h61, $urandom & 8'hfe);
        foreach (mdl[a]) op(1'b1, a, a == 8'h61 ? mdl[a] : $urandom);
        op(1'b1, 8'h63, 8'hff);
        poll(0);
        foreach (mdl[a]) op(1'b0, a, 0);
        op(1'b0, 8'h63, 0);
        outs;
        $display("random access done");
        op(1'b1, 8'h62, 8'h05);
        op(1'b1, 8'h6b, 8'h00);
        op(1'b1, 8'h6c, 8'h01);
        op(1'b1, 8'h61, 8'h01);
        @(posedge core_clk_i) #1 chk("fgos", {6'h0, fg_offset_o, fg_run_o}, 3);
        poll(3);
        for (int i = 0; i < 8; i++) begin
            op(1'b1, 8'h6b, i & 1);
            op(1'b1, 8'h6c, i >> 1 & 1);
            calibration_trigger_pin_i = i[2];
            #1 outs;
        end
        $display("trigger source done");
        op(1'b1, 8'h61, 8'h00);
        op(1'b1, 8'h62, 8'h0a);
        op(1'b1, 8'h6b, 8'h00);
        op(1'b1, 8'h6c, 8'h01);
        op(1'b1, 8'h61, 8'h01);
        poll(1);
        chk("bg", {5'h0, fg_run_o, bg_offset_o, bg_run_o}, 3);
        for (int s = 0; s < 4; s++) begin
            op(1'b1, 8'h6b, s << 1);
            fault_i = 1'($urandom);
            @(posedge core_clk_i) #1 outs;
        end
        op(1'b1, 8'h6c, 8'h00);
        poll(3);
        chk("bg", {7'h0, bg_run_o}, 0);
        $display("background done");
        final_report;
    end
endmodule
